// [hw/msc_ctrl.sv]
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Function
// - shared pin output is open-drain only, never driven high
// - clock mode bit 0 set and pin input makes it external reset
// - entering the service routine clears global interrupt enable
// - return from interrupt sets global interrupt enable again
// - interrupt enable and request registers must be written before use
// - global disable blocks cpu_irq until enabled again; evt_irq is not gated by it
// - watchdog stops and stays inactive while low-speed oscillator is off
// - timer interrupt on each rising edge of selected count bit
// - after timer restart next interrupt comes at next rising edge
// - low-voltage reset acts only after power-on has completed
// - auxiliary bit 2 set disables low-voltage reset
// - watchdog period codes give 8K, 16K, 64K, 256K slow periods
// - fast wake-up resumes after 32 low-speed oscillator periods
module msc_ctrl #(
  parameter int WDT_UNIT       = 1024,
  parameter int SLOW_WAKE_LRC  = 1024
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic [msc_pkg::AW-1:0]    reg_addr,
  input  wire logic [msc_pkg::DW-1:0]    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [msc_pkg::DW-1:0]    reg_rdata,
  input  wire logic                      isr_enter,
  input  wire logic                      reti_exec,
  input  wire logic                      engint_exec,
  input  wire logic                      disgint_exec,
  input  wire logic                      wdreset_exec,
  input  wire logic                      sleep_req,
  input  wire logic [msc_pkg::DW-1:0]    irq_src,
  input  wire logic                      t16_tick,
  input  wire logic [msc_pkg::NPIN-1:0]  pin_in,
  input  wire logic                      lrc_clk_in,
  input  wire logic                      por_done,
  input  wire logic                      lvr_trip,
  output logic                           shared_reset_pin_out,
  output logic                           shared_reset_pin_oe,
  output logic                           external_reset_input,
  output logic                           chip_reset,
  output logic                           cpu_irq,
  output logic                           gie,
  output logic                           cpu_run,
  output logic                           evt_irq,
  output logic                           low_speed_rc_osc_en,
  output logic                           high_speed_rc_osc_en,
  output logic      [2:0]                clk_src_sel,
  output logic                           lvr_armed
);
  import msc_pkg::*;

  localparam int WDTW = $clog2(WDT_UNIT * WDT_MUL3) + 1;

  typedef struct packed {
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_d;
    logic            lrc_s1;
    logic            lrc_s2;
    logic            lrc_d;
    logic            por_s1;
    logic            por_s2;
    logic            lvr_s1;
    logic            lvr_s2;
    logic [DW-1:0]   clock_mode_reg;
    logic [DW-1:0]   aux_ctrl;
    logic [DW-1:0]   pin_wake_enable;
    logic [DW-1:0]   irq_enable_reg;
    logic [DW-1:0]   irq_request_reg;
    logic [DW-1:0]   timer16_mode;
    logic [DW-1:0]   pin_ctrl;
    logic [15:0]     t16_cnt;
    logic [EVW-1:0]  evt_stat;
    logic [EVW-1:0]  evt_en;
    logic            gie;
    logic [WDTW-1:0] wdt_cnt;
    logic [15:0]     wake_cnt;
    msc_pwr_e        pwr;
    logic            chip_reset;
    logic            xrst;
    logic [DW-1:0]   rdata;
  } msc_state_s;

  msc_state_s      s;
  msc_state_s      next_s;
  logic            lrc_rise;
  logic [15:0]     t16_next;
  logic [3:0]      t16_idx;
  logic            t16_edge;
  logic [WDTW-1:0] wdt_lim;
  logic            wdt_active;
  logic            wdt_fire;
  logic [15:0]     wake_len;
  logic            wake_evt;
  logic            xrst;
  logic            lvr_fire;
  logic [EVW-1:0]  evt_set;
  logic [DW-1:0]   irq_set;
  logic            wr_any;

  always_comb begin
    next_s   = s;
    wr_any   = reg_wr;
    next_s.rdata      = '0;
    next_s.chip_reset = 1'h0;

    // two-stage synchronisers; only the second stage and its delayed copy feed logic
    next_s.pin_s1 = pin_in;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_d  = s.pin_s2;
    next_s.lrc_s1 = lrc_clk_in;
    next_s.lrc_s2 = s.lrc_s1;
    next_s.lrc_d  = s.lrc_s2;
    next_s.por_s1 = por_done;
    next_s.por_s2 = s.por_s1;
    next_s.lvr_s1 = lvr_trip;
    next_s.lvr_s2 = s.lvr_s1;
    lrc_rise = s.lrc_s2 & ~s.lrc_d;

    // global enable: entry and disable win over a same-cycle enable
    if (engint_exec || reti_exec) begin
      next_s.gie = 1'h1;
    end
    if (disgint_exec || isr_enter) begin
      next_s.gie = 1'h0;
    end

    // 16-bit timer; interrupt on a 0-to-1 step of the chosen count bit
    // selection picks count bit 8 to 15; bit 8 gives one request per 512 counts
    t16_idx  = 4'(T16_BASE_BIT) + {1'h0, s.timer16_mode[T16_SEL_LSB +: 3]};
    t16_next = s.t16_cnt;
    if (s.timer16_mode[T16_RUN] && t16_tick) begin
      t16_next = s.t16_cnt + 16'h0001;
    end
    t16_edge = ~s.t16_cnt[t16_idx] & t16_next[t16_idx];
    next_s.t16_cnt = t16_next;

    // external reset through the shared pin, active low, input mode only
    xrst = s.clock_mode_reg[CM_PIN_RST] & ~s.pin_ctrl[PC_OUT_MODE]
         & ~s.pin_s2[SHARED_PIN_IDX];
    // registered copy lags one cycle but gives the event flag a clean edge
    next_s.xrst = xrst;

    // low-voltage reset only once power-on is done and not disabled
    lvr_fire = s.por_s2 & ~s.aux_ctrl[AUX_LVR_DIS] & s.lvr_s2;

    // watchdog counts low-speed periods; frozen while that oscillator is off
    unique case (s.aux_ctrl[AUX_WDT_LSB +: 2])
      2'h0: wdt_lim = WDTW'(WDT_UNIT * WDT_MUL0 - 1);
      2'h1: wdt_lim = WDTW'(WDT_UNIT * WDT_MUL1 - 1);
      2'h2: wdt_lim = WDTW'(WDT_UNIT * WDT_MUL2 - 1);
      2'h3: wdt_lim = WDTW'(WDT_UNIT * WDT_MUL3 - 1);
    endcase
    wdt_active = s.clock_mode_reg[CM_LRC_EN] & s.clock_mode_reg[CM_WDT_EN];
    wdt_fire   = 1'h0;
    // count is held, not cleared, while inactive; only the clear instruction restarts it
    if (wdreset_exec) begin
      next_s.wdt_cnt = '0;
    end else if (wdt_active && lrc_rise) begin
      if (s.wdt_cnt >= wdt_lim) begin
        next_s.wdt_cnt = '0;
        wdt_fire       = 1'h1;
      end else begin
        next_s.wdt_cnt = s.wdt_cnt + WDTW'(1);
      end
    end
    next_s.chip_reset = wdt_fire | xrst | lvr_fire;

    // sleep and wake-up sequencing
    wake_evt = |((s.pin_s2 ^ s.pin_d) & s.pin_wake_enable);
    wake_len = s.aux_ctrl[AUX_FAST_WAKE] ? 16'(FAST_WAKE_LRC - 1)
                                         : 16'(SLOW_WAKE_LRC - 1);
    // the wake count stalls if the slow oscillator is stopped from outside
    unique case (s.pwr)
      PWR_RUN: begin
        if (sleep_req) begin
          next_s.pwr = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (wake_evt) begin
          next_s.pwr      = PWR_WAKE;
          next_s.wake_cnt = '0;
        end
      end
      PWR_WAKE: begin
        if (lrc_rise) begin
          if (s.wake_cnt >= wake_len) begin
            next_s.pwr = PWR_RUN;
          end else begin
            next_s.wake_cnt = s.wake_cnt + 16'h0001;
          end
        end
      end
      // the spare state code falls back to run
      default: begin
        next_s.pwr = PWR_RUN;
      end
    endcase

    // event flags
    // sticky: hardware sets them, software clears them by writing ones
    evt_set = '0;
    evt_set[EV_T16]  = t16_edge;
    evt_set[EV_WAKE] = (s.pwr == PWR_SLEEP) & wake_evt;
    evt_set[EV_WDT]  = wdt_fire;
    evt_set[EV_XRST] = xrst & ~s.xrst;
    evt_set[EV_LVR]  = lvr_fire;
    irq_set = irq_src;
    irq_set[IRQ_T16] = irq_src[IRQ_T16] | t16_edge;

    // register writes
    // a clock switch that also stops the running source is not blocked here
    if (wr_any) begin
      unique case (reg_addr)
        A_CLOCK_MODE: next_s.clock_mode_reg  = reg_wdata;
        A_AUX_CTRL:   next_s.aux_ctrl        = reg_wdata;
        A_PIN_WAKE:   next_s.pin_wake_enable = reg_wdata;
        A_IRQ_EN:     next_s.irq_enable_reg  = reg_wdata;
        A_IRQ_REQ:    next_s.irq_request_reg = reg_wdata;
        A_PIN_CTRL:   next_s.pin_ctrl        = reg_wdata;
        A_T16_LO:     next_s.t16_cnt[7:0]    = reg_wdata;
        A_T16_HI:     next_s.t16_cnt[15:8]   = reg_wdata;
        A_EVT_CLR:    next_s.evt_stat        = s.evt_stat & ~reg_wdata[EVW-1:0];
        A_EVT_EN:     next_s.evt_en          = reg_wdata[EVW-1:0];
        A_T16_MODE: begin
          next_s.timer16_mode = reg_wdata;
          next_s.timer16_mode[T16_RESTART] = 1'h0;
          // restart zeroes the count so no stale edge is seen
          if (reg_wdata[T16_RESTART]) begin
            next_s.t16_cnt = '0;
          end
        end
        default: begin
          // status index and unused indices: writes are dropped
        end
      endcase
    end

    // hardware sets win over a same-cycle software clear
    next_s.irq_request_reg = next_s.irq_request_reg | irq_set;
    next_s.evt_stat        = next_s.evt_stat | evt_set;

    // register reads, data in the following cycle
    if (reg_rd) begin
      unique case (reg_addr)
        A_CLOCK_MODE: next_s.rdata = s.clock_mode_reg;
        A_AUX_CTRL:   next_s.rdata = s.aux_ctrl;
        A_PIN_WAKE:   next_s.rdata = s.pin_wake_enable;
        A_IRQ_EN:     next_s.rdata = s.irq_enable_reg;
        A_IRQ_REQ:    next_s.rdata = s.irq_request_reg;
        A_T16_MODE:   next_s.rdata = s.timer16_mode;
        A_PIN_CTRL:   next_s.rdata = s.pin_ctrl;
        A_T16_LO:     next_s.rdata = s.t16_cnt[7:0];
        A_T16_HI:     next_s.rdata = s.t16_cnt[15:8];
        A_EVT_STAT:   next_s.rdata = DW'(s.evt_stat);
        A_EVT_EN:     next_s.rdata = DW'(s.evt_en);
        default:      next_s.rdata = '0;
      endcase
    end
  end

  // reset acts even while the clock enable is low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s                <= '0;
      s.clock_mode_reg <= CLOCK_MODE_RST;
      s.pwr            <= PWR_RUN;
      // pins idle high on their pull-ups; resetting low would fake a wake edge
      s.pin_s1         <= '1;
      s.pin_s2         <= '1;
      s.pin_d          <= '1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign reg_rdata            = s.rdata;
  // open drain: only ever pulls low, high comes from an outside pull-up
  assign shared_reset_pin_out = 1'h0;
  assign shared_reset_pin_oe  = s.pin_ctrl[PC_OUT_MODE] & ~s.pin_ctrl[PC_OUT_LVL];
  assign external_reset_input = s.xrst;
  assign chip_reset           = s.chip_reset;
  assign gie                  = s.gie;
  // nothing reaches the core on cpu_irq while global enable is low
  assign cpu_irq              = s.gie & |(s.irq_request_reg & s.irq_enable_reg);
  assign cpu_run              = (s.pwr == PWR_RUN);
  assign evt_irq              = |(s.evt_stat & s.evt_en);
  assign low_speed_rc_osc_en  = s.clock_mode_reg[CM_LRC_EN];
  assign high_speed_rc_osc_en = s.clock_mode_reg[CM_HRC_EN];
  assign clk_src_sel          = s.clock_mode_reg[CM_SEL_LSB +: 3];
  assign lvr_armed            = s.por_s2 & ~s.aux_ctrl[AUX_LVR_DIS];

endmodule // msc_ctrl

// [hw/msc_pkg.sv]
package msc_pkg;
  localparam int AW = 4;
  localparam int DW = 8;
  localparam int NPIN = 8;
  localparam int SHARED_PIN_IDX = 5;

  // register indices on the plain register port
  localparam logic [AW-1:0] A_CLOCK_MODE = 4'h0;
  localparam logic [AW-1:0] A_AUX_CTRL   = 4'h1;
  localparam logic [AW-1:0] A_PIN_WAKE   = 4'h2;
  localparam logic [AW-1:0] A_IRQ_EN     = 4'h3;
  localparam logic [AW-1:0] A_IRQ_REQ    = 4'h4;
  localparam logic [AW-1:0] A_T16_MODE   = 4'h5;
  localparam logic [AW-1:0] A_PIN_CTRL   = 4'h6;
  localparam logic [AW-1:0] A_T16_LO     = 4'h7;
  localparam logic [AW-1:0] A_T16_HI     = 4'h8;
  localparam logic [AW-1:0] A_EVT_STAT   = 4'h9;
  localparam logic [AW-1:0] A_EVT_CLR    = 4'ha;
  localparam logic [AW-1:0] A_EVT_EN     = 4'hb;

  // clock_mode_reg fields
  localparam int CM_PIN_RST = 0;
  localparam int CM_WDT_EN  = 1;
  localparam int CM_LRC_EN  = 2;
  localparam int CM_HRC_EN  = 4;
  localparam int CM_SEL_LSB = 5;
  localparam logic [DW-1:0] CLOCK_MODE_RST = 8'h04;

  // auxiliary control fields
  localparam int AUX_WDT_LSB   = 0;
  localparam int AUX_LVR_DIS   = 2;
  localparam int AUX_FAST_WAKE = 3;

  // timer16_mode fields
  localparam int T16_SEL_LSB  = 0;
  localparam int T16_RUN      = 3;
  localparam int T16_RESTART  = 4;
  localparam int T16_BASE_BIT = 8;
  localparam int IRQ_T16      = 2;

  // shared pin control fields
  localparam int PC_OUT_MODE = 0;
  localparam int PC_OUT_LVL  = 1;

  // event status bits
  localparam int EV_T16  = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_WDT  = 2;
  localparam int EV_XRST = 3;
  localparam int EV_LVR  = 4;
  localparam int EVW     = 5;

  // watchdog timeout multiples of one K of low-speed periods
  localparam int WDT_MUL0 = 8;
  localparam int WDT_MUL1 = 16;
  localparam int WDT_MUL2 = 64;
  localparam int WDT_MUL3 = 256;
  localparam int FAST_WAKE_LRC = 32;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_WAKE} msc_pwr_e;
endpackage

// [tb/msc_ctrl_chk.sv]
`timescale 1ns/1ps
module msc_ctrl_chk (
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   reg_rd,
  input wire logic [msc_pkg::DW-1:0] reg_rdata,
  input wire logic                   isr_enter,
  input wire logic                   reti_exec,
  input wire logic                   disgint_exec,
  input wire logic                   lvr_trip,
  input wire logic                   por_done,
  input wire logic                   shared_reset_pin_out,
  input wire logic                   shared_reset_pin_oe,
  input wire logic                   external_reset_input,
  input wire logic                   chip_reset,
  input wire logic                   cpu_irq,
  input wire logic                   gie,
  input wire logic                   low_speed_rc_osc_en,
  input wire logic                   lvr_armed
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_pin_never_high: assert property (shared_reset_pin_out == 1'h0)
    else $error("shared pin driven high");
  a_isr_clears_gie: assert property (isr_enter |=> !gie && !cpu_irq)
    else $error("gie kept on service entry");
  a_reti_sets_gie: assert property (reti_exec && !isr_enter && !disgint_exec |=> gie)
    else $error("gie not restored by return");
  a_gdis_blocks: assert property (!gie |-> !cpu_irq)
    else $error("irq passed while gie low");
  a_wdt_idle_lrc: assert property (
    (!low_speed_rc_osc_en && !lvr_trip && !external_reset_input)[*4] |-> !chip_reset)
    else $error("reset while slow osc off");
  a_lvr_after_por: assert property (!por_done[*4] |-> !lvr_armed)
    else $error("lvr armed before power-on done");
  a_ext_reset_out: assert property (external_reset_input |-> chip_reset)
    else $error("external reset not applied");
  a_pin_out_noreset: assert property (shared_reset_pin_oe |=> !external_reset_input)
    else $error("output pin acted as reset");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule // msc_ctrl_chk
bind msc_ctrl msc_ctrl_chk chk_u (.clk_sys, .rst, .reg_rd, .reg_rdata, .isr_enter, .reti_exec, .disgint_exec,
  .lvr_trip, .por_done, .shared_reset_pin_out, .external_reset_input, .chip_reset, .cpu_irq, .gie,
  .low_speed_rc_osc_en, .lvr_armed, .shared_reset_pin_oe);

// [tb/msc_ctrl_tb_top.sv]
`timescale 1ns/1ps
module msc_ctrl_tb_top;
  import msc_pkg::*;
  logic          clk_sys = 1'h0, rst = 1'h1, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic          t16_tick = 1'h0, lrc_clk_in = 1'h0, por_done = 1'h0, lvr_trip = 1'h0;
  logic [AW-1:0] reg_addr = 4'h0;
  logic [DW-1:0] reg_wdata = 8'h00, irq_src = 8'h00, pin_in = 8'hff, reg_rdata;
  logic [5:0]    core_p = 6'h00;
  logic [2:0]    clk_src_sel;
  logic          shared_reset_pin_out, shared_reset_pin_oe, external_reset_input, chip_reset, cpu_irq;
  logic          gie, cpu_run, evt_irq, low_speed_rc_osc_en, high_speed_rc_osc_en, lvr_armed;
  int            err_count = 0, checks_done = 0, c = 0;
  always #5 clk_sys = ~clk_sys;
  // slow osc period 82 ns, deliberately not a multiple of the system clock
  always #41 lrc_clk_in = ~lrc_clk_in;
  msc_ctrl #(.WDT_UNIT(4), .SLOW_WAKE_LRC(8)) dut_u (
    .clk_sys, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .isr_enter(core_p[0]), .reti_exec(core_p[1]), .engint_exec(core_p[2]), .disgint_exec(core_p[3]),
    .wdreset_exec(core_p[4]), .sleep_req(core_p[5]), .irq_src, .t16_tick, .pin_in, .lrc_clk_in, .por_done,
    .lvr_trip, .shared_reset_pin_out, .shared_reset_pin_oe, .external_reset_input, .chip_reset, .cpu_irq,
    .gie, .cpu_run, .evt_irq, .low_speed_rc_osc_en, .high_speed_rc_osc_en, .clk_src_sel, .lvr_armed);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string what);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 check(what, reg_rdata, exp);
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_sys);
    core_p <= m;
    @(posedge clk_sys);
    core_p <= 6'h00;
    #1;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic ticks(input int n);
    @(posedge clk_sys);
    t16_tick <= 1'h1;
    repeat (n) @(posedge clk_sys);
    t16_tick <= 1'h0;
  endtask
  task automatic wait_hi(input logic sel, input int lim);
    c = 0;
    while ((sel ? cpu_run : chip_reset) !== 1'h1 && c < lim) begin
      @(posedge clk_sys);
      #1 c++;
    end
    if (c >= lim) begin
      err_count++;
      $display("mismatch wait expected 1 seen 0");
      complete_run();
    end
  endtask
  task automatic t_regs();
    rd(A_CLOCK_MODE, CLOCK_MODE_RST, "clock_mode reset");
    rd(4'hc, 8'h00, "unmapped");
    rd(A_EVT_CLR, 8'h00, "evt clear read");
    wr(A_EVT_STAT, 8'h1f);
    rd(A_EVT_STAT, 8'h00, "evt stat read-only");
    wr(A_CLOCK_MODE, 8'h34);
    wr(A_CLOCK_MODE, 8'h30);
    #1 check("clk sel", {low_speed_rc_osc_en, high_speed_rc_osc_en, clk_src_sel}, 16'h09);
    wr(A_CLOCK_MODE, 8'h04);
    $display("test regs end");
  endtask
  task automatic t_irq();
    wr(A_IRQ_EN, 8'h05);
    wr(A_IRQ_REQ, 8'h00);
    pulse(6'h04);
    @(posedge clk_sys);
    irq_src <= 8'h01;
    @(posedge clk_sys);
    irq_src <= 8'h00;
    settle();
    check("cpu_irq", cpu_irq, 1'h1);
    pulse(6'h01);
    check("gie isr", {gie, cpu_irq}, 16'h0);
    pulse(6'h02);
    check("gie reti", {gie, cpu_irq}, 16'h3);
    pulse(6'h08);
    check("gie off", {gie, cpu_irq}, 16'h0);
    @(posedge clk_sys);
    ce <= 1'h0;
    pulse(6'h04);
    @(posedge clk_sys);
    ce <= 1'h1;
    #1 check("gie frozen", gie, 1'h0);
    wr(A_IRQ_REQ, 8'h00);
    $display("test irq end");
  endtask
  task automatic t_timer();
    int n[3] = '{256, 512, 256};
    for (int i = 0; i < 3; i++) begin
      if (i != 1) wr(A_T16_MODE, 8'h18);
      wr(A_IRQ_REQ, 8'h00);
      ticks(n[i] - 1);
      rd(A_IRQ_REQ, 8'h00, "t16 early");
      ticks(1);
      rd(A_IRQ_REQ, 8'h04, "t16 irq");
    end
    $display("test timer end");
  endtask
  task automatic t_pins();
    wr(A_CLOCK_MODE, 8'h05);
    wr(A_PIN_CTRL, 8'h00);
    pin_in <= 8'hdf;
    settle();
    check("ext reset", {external_reset_input, chip_reset}, 16'h3);
    wr(A_PIN_CTRL, 8'h01);
    settle();
    check("pin out", {external_reset_input, shared_reset_pin_oe, shared_reset_pin_out}, 16'h2);
    wr(A_PIN_CTRL, 8'h03);
    #1 check("pin released", shared_reset_pin_oe, 1'h0);
    wr(A_CLOCK_MODE, 8'h04);
    wr(A_PIN_CTRL, 8'h00);
    pin_in <= 8'hff;
    lvr_trip <= 1'h1;
    settle();
    check("lvr pre por", chip_reset, 1'h0);
    @(posedge clk_sys);
    por_done <= 1'h1;
    settle();
    check("lvr", {lvr_armed, chip_reset}, 16'h3);
    wr(A_AUX_CTRL, 8'h04);
    settle();
    check("lvr off", {lvr_armed, chip_reset}, 16'h0);
    @(posedge clk_sys);
    lvr_trip <= 1'h0;
    $display("test pins end");
  endtask
  task automatic t_wdt();
    int mul[4] = '{WDT_MUL0, WDT_MUL1, WDT_MUL2, WDT_MUL3};
    int e;
    logic seen;
    wr(A_CLOCK_MODE, 8'h06);
    for (int k = 0; k < 4; k++) begin
      wr(A_AUX_CTRL, 8'(k));
      pulse(6'h10);
      wait_hi(1'h0, 12000);
      e = 4 * mul[k] * 82 / 10;
      check("wdt period", c > e - 24 && c < e + 24, 1'h1);
    end
    wr(A_AUX_CTRL, 8'h00);
    pulse(6'h10);
    wr(A_CLOCK_MODE, 8'h02);
    seen = 1'h0;
    repeat (600) begin
      @(posedge clk_sys);
      #1 seen |= chip_reset;
    end
    check("wdt idle", seen, 1'h0);
    wr(A_CLOCK_MODE, 8'h04);
    $display("test wdt end");
  endtask
  task automatic t_wake();
    wr(A_EVT_CLR, 8'h1f);
    wr(A_EVT_EN, 8'h02);
    wr(A_PIN_WAKE, 8'h01);
    wr(A_AUX_CTRL, 8'h08);
    pulse(6'h20);
    check("sleep", cpu_run, 1'h0);
    @(posedge clk_sys);
    pin_in <= 8'hfe;
    wait_hi(1'h1, 2000);
    check("fast wake", c > 238 && c < 290, 1'h1);
    check("evt irq", evt_irq, 1'h1);
    rd(A_EVT_STAT, 8'h02, "evt stat");
    wr(A_EVT_EN, 8'h00);
    settle();
    check("evt masked", evt_irq, 1'h0);
    wr(A_EVT_CLR, 8'h02);
    rd(A_EVT_STAT, 8'h00, "evt cleared");
    $display("test wake end");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    t_regs();
    t_irq();
    t_timer();
    t_pins();
    t_wdt();
    t_wake();
    complete_run();
  end
endmodule // msc_ctrl_tb_top
